// ==== rtl/sdich_map.svh ====
// Character codes, size limits and CRC constants of the command handler.
// Assumes ASCII characters arrive already framed by a serial receiver.
`ifndef SDICH_MAP_SVH
`define SDICH_MAP_SVH

`define SDICH_CH_CR    8'h0d
`define SDICH_CH_LF    8'h0a
`define SDICH_CH_BANG  8'h21
`define SDICH_CH_PLUS  8'h2b
`define SDICH_CH_MINUS 8'h2d
`define SDICH_CH_QMARK 8'h3f
`define SDICH_CH_ZERO  8'h30
`define SDICH_CH_ONE   8'h31
`define SDICH_CH_NINE  8'h39
`define SDICH_CH_C     8'h43
`define SDICH_CH_D     8'h44
`define SDICH_CH_M     8'h4d
`define SDICH_CH_R     8'h52
`define SDICH_CH_X     8'h58

// Longest command kept, excluding the terminator
`define SDICH_CMD_MAX  4'h8
`define SDICH_CMD_OVF  4'hf
// Data characters per chunk
`define SDICH_STD_LIM  7'h23
`define SDICH_CONC_LIM 7'h4b
// CRC-16, reflected polynomial, zero start
`define SDICH_CRC_INIT 16'h0000
`define SDICH_CRC_POLY 16'ha001

`endif

// ==== rtl/sdich_pkg.sv ====
// Types of the sensor command handler: states, modes and the state record.
// Assumes sdich_map.svh supplies the numeric constants.
package sdich_pkg;

  typedef enum logic [1:0] {
    SDICH_RX    = 2'b00,
    SDICH_EXEC  = 2'b01,
    SDICH_SHORT = 2'b10,
    SDICH_DATA  = 2'b11
  } sdich_st_t;

  typedef enum logic [1:0] {
    SDICH_NONE = 2'b00,
    SDICH_STD  = 2'b01,
    SDICH_CONC = 2'b10
  } sdich_mode_t;

  typedef struct packed {
    sdich_st_t        st;
    logic [7:0][7:0]  cbuf;
    logic [3:0]       clen;
    sdich_mode_t      mode;
    logic             mcrc;
    logic             dconc;
    logic             sr_pend;
    logic             dcrc;
    logic             dwide;
    logic             todata;
    logic [15:0]      crc;
    logic [7:0][7:0]  tbuf;
    logic [3:0]       tlen;
    logic [3:0]       tidx;
    logic [6:0]       dcnt;
    logic [7:0]       tx_byte;
    logic             tx_vld;
    logic             start;
    logic             start_conc;
    logic             abort;
    logic             dreq;
    logic             dcont;
    logic             xcmd;
    logic [3:0]       idx;
  } sdich_state_t;

endpackage

// ==== rtl/sdich_handler.sv ====
// Sensor-side command interpreter: measurement, data, abort and extended.
// Assumes a UART feeds received characters and a bus-break pulse, and a
// measurement core supplies timing digits and the value character stream.
//
// Operation
// - Concurrent reply: address, ttt, nn, CR LF
// - Concurrent measurement never sends service request
// - CRC variants append three CRC characters
// - Break abandons pending standard measurement
// - Other valid command aborts concurrent measurement
// - Data fetched by indexed commands zero-nine
// - Standard chunk holds at most 35 characters
// - Concurrent chunk holds at most 75 characters
// - Values lead with plus or minus sign
// - Extended: address, X, letters, exclamation
// - Extended reply: address, CR LF
// - Standard completion sends address CR LF
`timescale 1ns/1ps
`include "sdich_map.svh"

module sdich_handler (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Own address
  input  wire logic [7:0]  addr_i,
  // Received characters and bus break
  input  wire logic [7:0]  rx_char_i,
  input  wire logic        rx_valid_i,
  input  wire logic        brk_i,
  // Transmit characters
  output logic      [7:0]  tx_char_o,
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  // Measurement core control
  input  wire logic [23:0] meas_ttt_i,
  input  wire logic [15:0] meas_nn_i,
  input  wire logic        meas_done_i,
  output logic             meas_start_o,
  output logic             meas_conc_o,
  output logic             meas_abort_o,
  output logic      [3:0]  cmd_idx_o,
  output logic             ext_cmd_o,
  // Value stream of one chunk
  output logic             data_req_o,
  output logic             data_cont_o,
  input  wire logic [7:0]  data_char_i,
  input  wire logic        data_valid_i,
  input  wire logic        data_end_i,
  output logic             data_ready_o
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [15:0] crc16(input logic [15:0] c,
                                        input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `SDICH_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic is_dig(input logic [7:0] ch);
    return (ch >= `SDICH_CH_ZERO) && (ch <= `SDICH_CH_NINE);
  endfunction

  function automatic logic is_sign(input logic [7:0] ch);
    return (ch == `SDICH_CH_PLUS) || (ch == `SDICH_CH_MINUS);
  endfunction

  function automatic logic [6:0] lim_of(input logic wide);
    return wide ? `SDICH_CONC_LIM : `SDICH_STD_LIM;
  endfunction

  // ************************************************************
  // Reset release
  // ************************************************************
  logic rst_m_ff;
  logic rst_sync_ff;

  // Two stages so release never meets a clock edge mid-way
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_m_ff    <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_m_ff    <= 1'b1;
      rst_sync_ff <= rst_m_ff;
    end
  end

  // ************************************************************
  // State and next state
  // ************************************************************
  sdich_pkg::sdich_state_t s_ff;
  sdich_pkg::sdich_state_t nxt_s;
  logic                    hc;
  logic [3:0]              dp;
  logic                    ok;
  logic                    meas;
  logic                    dat;
  logic [7:0]              ch;

  always_comb begin
    nxt_s = s_ff;
    hc    = 1'b0;
    dp    = 4'h2;
    ok    = 1'b0;
    meas  = 1'b0;
    dat   = 1'b0;
    ch    = data_char_i;
    nxt_s.start = 1'b0;
    nxt_s.abort = 1'b0;
    nxt_s.dreq  = 1'b0;
    nxt_s.xcmd  = 1'b0;
    if (s_ff.tx_vld && tx_ready_i) begin
      nxt_s.tx_vld = 1'b0;
    end
    // Completion: only standard mode raises a service request
    if (meas_done_i) begin
      if (s_ff.mode == sdich_pkg::SDICH_STD) begin
        nxt_s.sr_pend = 1'b1;
      end
      nxt_s.mode = sdich_pkg::SDICH_NONE;
    end
    unique case (s_ff.st)
      sdich_pkg::SDICH_RX: begin
        if (rx_valid_i) begin
          if (rx_char_i == `SDICH_CH_BANG) begin
            nxt_s.st = sdich_pkg::SDICH_EXEC;
          end else if (s_ff.clen < `SDICH_CMD_MAX) begin
            nxt_s.cbuf[s_ff.clen[2:0]] = rx_char_i;
            nxt_s.clen = s_ff.clen + 4'h1;
          end else begin
            nxt_s.clen = `SDICH_CMD_OVF;
          end
        end else if (s_ff.sr_pend && s_ff.clen == 4'h0) begin
          // Service request waits for a quiet line
          nxt_s.sr_pend = 1'b0;
          nxt_s.tbuf[0] = addr_i;
          nxt_s.tbuf[1] = `SDICH_CH_CR;
          nxt_s.tbuf[2] = `SDICH_CH_LF;
          nxt_s.tlen    = 4'h3;
          nxt_s.tidx    = 4'h0;
          nxt_s.todata  = 1'b0;
          nxt_s.st      = sdich_pkg::SDICH_SHORT;
        end
      end
      sdich_pkg::SDICH_EXEC: begin
        nxt_s.clen = 4'h0;
        nxt_s.st   = sdich_pkg::SDICH_RX;
        if (s_ff.clen >= 4'h3 && s_ff.cbuf[2] == `SDICH_CH_C) begin
          hc = 1'b1;
          dp = 4'h3;
        end
        if (s_ff.cbuf[0] == `SDICH_CH_QMARK && s_ff.clen == 4'h1) begin
          ok = 1'b1;
        end else if (s_ff.cbuf[0] == addr_i && s_ff.clen != 4'h0 &&
                     s_ff.clen != `SDICH_CMD_OVF) begin
          if (s_ff.clen == 4'h1) begin
            ok = 1'b1;
          end else if (s_ff.cbuf[1] == `SDICH_CH_M ||
                       s_ff.cbuf[1] == `SDICH_CH_C) begin
            if (s_ff.clen == dp) begin
              meas = 1'b1;
              nxt_s.idx = 4'h0;
            end else if (s_ff.clen == dp + 4'h1 &&
                         s_ff.cbuf[dp[2:0]] >= `SDICH_CH_ONE &&
                         is_dig(s_ff.cbuf[dp[2:0]])) begin
              meas = 1'b1;
              nxt_s.idx = s_ff.cbuf[dp[2:0]][3:0];
            end
          end else if (s_ff.cbuf[1] == `SDICH_CH_D && s_ff.clen == 4'h3 &&
                       is_dig(s_ff.cbuf[2])) begin
            dat = 1'b1;
            nxt_s.idx   = s_ff.cbuf[2][3:0];
            nxt_s.dcont = 1'b0;
            nxt_s.dcrc  = s_ff.mcrc;
            nxt_s.dwide = s_ff.dconc;
          end else if (s_ff.cbuf[1] == `SDICH_CH_R &&
                       s_ff.clen == dp + 4'h1 &&
                       is_dig(s_ff.cbuf[dp[2:0]])) begin
            dat = 1'b1;
            nxt_s.idx   = s_ff.cbuf[dp[2:0]][3:0];
            nxt_s.dcont = 1'b1;
            nxt_s.dcrc  = hc;
            nxt_s.dwide = 1'b1;
          end else if (s_ff.cbuf[1] == `SDICH_CH_X) begin
            ok = 1'b1;
            nxt_s.xcmd = 1'b1;
          end
        end
        ok = ok | meas | dat;
        if (ok) begin
          // Plain acknowledgement form, widened below for measurements and cut to the address for data
          nxt_s.tbuf[0] = addr_i;
          nxt_s.tbuf[1] = `SDICH_CH_CR;
          nxt_s.tbuf[2] = `SDICH_CH_LF;
          nxt_s.tlen    = 4'h3;
          nxt_s.tidx    = 4'h0;
          nxt_s.todata  = 1'b0;
          nxt_s.st      = sdich_pkg::SDICH_SHORT;
        end
        // A valid command before time-out ends the concurrent run
        if (ok && s_ff.mode == sdich_pkg::SDICH_CONC && !meas_done_i) begin
          nxt_s.abort = 1'b1;
          nxt_s.mode  = sdich_pkg::SDICH_NONE;
        end
        if (meas) begin
          nxt_s.start      = 1'b1;
          nxt_s.start_conc = (s_ff.cbuf[1] == `SDICH_CH_C);
          nxt_s.mcrc       = hc;
          nxt_s.dconc      = nxt_s.start_conc;
          nxt_s.sr_pend    = 1'b0;
          nxt_s.mode       = nxt_s.start_conc ? sdich_pkg::SDICH_CONC :
                                                sdich_pkg::SDICH_STD;
          nxt_s.tbuf[1] = meas_ttt_i[23:16];
          nxt_s.tbuf[2] = meas_ttt_i[15:8];
          nxt_s.tbuf[3] = meas_ttt_i[7:0];
          if (nxt_s.start_conc) begin
            nxt_s.tbuf[4] = meas_nn_i[15:8];
            nxt_s.tbuf[5] = meas_nn_i[7:0];
            nxt_s.tbuf[6] = `SDICH_CH_CR;
            nxt_s.tbuf[7] = `SDICH_CH_LF;
            nxt_s.tlen    = 4'h8;
          end else begin
            nxt_s.tbuf[4] = meas_nn_i[7:0];
            nxt_s.tbuf[5] = `SDICH_CH_CR;
            nxt_s.tbuf[6] = `SDICH_CH_LF;
            nxt_s.tlen    = 4'h7;
          end
        end
        if (dat) begin
          nxt_s.dreq   = 1'b1;
          nxt_s.tlen   = 4'h1;
          nxt_s.todata = 1'b1;
          nxt_s.dcnt   = 7'h00;
          nxt_s.crc    = crc16(`SDICH_CRC_INIT, addr_i);
        end
      end
      sdich_pkg::SDICH_SHORT: begin
        if (!s_ff.tx_vld) begin
          if (s_ff.tidx < s_ff.tlen) begin
            nxt_s.tx_byte = s_ff.tbuf[s_ff.tidx[2:0]];
            nxt_s.tx_vld  = 1'b1;
            nxt_s.tidx    = s_ff.tidx + 4'h1;
          end else if (s_ff.todata) begin
            nxt_s.todata = 1'b0;
            nxt_s.st     = sdich_pkg::SDICH_DATA;
          end else begin
            nxt_s.st = sdich_pkg::SDICH_RX;
          end
        end
      end
      sdich_pkg::SDICH_DATA: begin
        if (!s_ff.tx_vld) begin
          // Truncation at the limit protects the master's buffer
          if (data_end_i || s_ff.dcnt == lim_of(s_ff.dwide)) begin
            nxt_s.tidx = 4'h0;
            nxt_s.st   = sdich_pkg::SDICH_SHORT;
            if (s_ff.dcrc) begin
              nxt_s.tbuf[0] = {4'h4, s_ff.crc[15:12]};
              nxt_s.tbuf[1] = {2'b01, s_ff.crc[11:6]};
              nxt_s.tbuf[2] = {2'b01, s_ff.crc[5:0]};
              nxt_s.tbuf[3] = `SDICH_CH_CR;
              nxt_s.tbuf[4] = `SDICH_CH_LF;
              nxt_s.tlen    = 4'h5;
            end else begin
              nxt_s.tbuf[0] = `SDICH_CH_CR;
              nxt_s.tbuf[1] = `SDICH_CH_LF;
              nxt_s.tlen    = 4'h2;
            end
          end else if (data_valid_i) begin
            if (s_ff.dcnt == 7'h00 && !is_sign(data_char_i)) begin
              ch = `SDICH_CH_PLUS;
            end
            nxt_s.tx_byte = ch;
            nxt_s.tx_vld  = 1'b1;
            nxt_s.dcnt    = s_ff.dcnt + 7'h01;
            nxt_s.crc     = crc16(s_ff.crc, ch);
          end
        end
      end
    endcase
    // Break drops any exchange and a pending standard run
    if (brk_i) begin
      nxt_s.st      = sdich_pkg::SDICH_RX;
      nxt_s.clen    = 4'h0;
      nxt_s.tx_vld  = 1'b0;
      nxt_s.sr_pend = 1'b0;
      if (s_ff.mode == sdich_pkg::SDICH_STD) begin
        nxt_s.abort = 1'b1;
        nxt_s.mode  = sdich_pkg::SDICH_NONE;
      end
    end
  end

  // Whole state in one register
  always_ff @(posedge clock_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign tx_char_o    = s_ff.tx_byte;
  assign tx_valid_o   = s_ff.tx_vld;
  assign meas_start_o = s_ff.start;
  assign meas_conc_o  = s_ff.start_conc;
  assign meas_abort_o = s_ff.abort;
  assign cmd_idx_o    = s_ff.idx;
  assign ext_cmd_o    = s_ff.xcmd;
  assign data_req_o   = s_ff.dreq;
  assign data_cont_o  = s_ff.dcont;
  // Held off while a sign is being inserted ahead of the value
  assign data_ready_o = (s_ff.st == sdich_pkg::SDICH_DATA) && !s_ff.tx_vld &&
                        !data_end_i && !brk_i &&
                        (s_ff.dcnt != lim_of(s_ff.dwide)) &&
                        !(s_ff.dcnt == 7'h00 && !is_sign(data_char_i));

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_sync_ff);

  sequence q_std_done;
    s_ff.mode == sdich_pkg::SDICH_STD && meas_done_i && !brk_i;
  endsequence
  sequence q_quiet;
    s_ff.st == sdich_pkg::SDICH_RX && s_ff.clen == 4'h0 &&
    !rx_valid_i && !brk_i;
  endsequence

  property p_conc_reply;
    s_ff.st == sdich_pkg::SDICH_EXEC && nxt_s.start && nxt_s.start_conc
    |=> s_ff.tlen == 4'h8 && s_ff.tbuf[7] == `SDICH_CH_LF;
  endproperty
  a_conc_reply: assert property (p_conc_reply)
    else $error("concurrent reply malformed");

  property p_no_srq;
    s_ff.mode == sdich_pkg::SDICH_CONC && meas_done_i && !s_ff.sr_pend
    |=> !s_ff.sr_pend;
  endproperty
  a_no_srq: assert property (p_no_srq)
    else $error("service request after concurrent run");

  property p_crc_tail;
    s_ff.st == sdich_pkg::SDICH_DATA && !s_ff.tx_vld && s_ff.dcrc &&
    data_end_i && !brk_i |=> s_ff.tlen == 4'h5;
  endproperty
  a_crc_tail: assert property (p_crc_tail)
    else $error("crc tail missing");

  property p_brk_abort;
    s_ff.mode == sdich_pkg::SDICH_STD && brk_i
    |=> meas_abort_o ##1 !meas_abort_o;
  endproperty
  a_brk_abort: assert property (p_brk_abort)
    else $error("break did not abort measurement");

  property p_std_lim;
    !s_ff.dwide |-> s_ff.dcnt <= `SDICH_STD_LIM;
  endproperty
  a_std_lim: assert property (p_std_lim)
    else $error("standard chunk too long");

  property p_conc_lim;
    s_ff.dcnt <= `SDICH_CONC_LIM;
  endproperty
  a_conc_lim: assert property (p_conc_lim)
    else $error("concurrent chunk too long");

  property p_sign;
    s_ff.st == sdich_pkg::SDICH_DATA && s_ff.dcnt == 7'h00 &&
    nxt_s.dcnt == 7'h01 && !brk_i |=> is_sign(tx_char_o) && tx_valid_o;
  endproperty
  a_sign: assert property (p_sign)
    else $error("value without sign");

  property p_srq;
    q_std_done ##1 q_quiet |=> s_ff.st == sdich_pkg::SDICH_SHORT &&
      s_ff.tlen == 4'h3 && s_ff.tbuf[1] == `SDICH_CH_CR;
  endproperty
  a_srq: assert property (p_srq)
    else $error("service request not sent");

  property p_foreign;
    s_ff.st == sdich_pkg::SDICH_EXEC && s_ff.cbuf[0] != addr_i &&
    s_ff.cbuf[0] != `SDICH_CH_QMARK && !brk_i && !s_ff.sr_pend &&
    !meas_done_i
    |=> s_ff.st == sdich_pkg::SDICH_RX [*2];
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("answered foreign address");

endmodule

// ==== verif/sdich_host_model.sv ====
// Behavioural data recorder acting as bus master of the command handler.
// Assumes the handler's receive side samples one character per rising edge.
`timescale 1ns/1ps

module sdich_host_model (
  // Clock
  input  wire logic       clock_i,
  // Characters towards the sensor
  output logic      [7:0] rx_char_o,
  output logic            rx_valid_o,
  output logic            brk_o,
  // Characters from the sensor
  input  wire logic [7:0] tx_char_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  // Stall control
  input  wire logic       slow_i
);
  logic [7:0] heard_q[$];
  logic       toggle;

  initial begin
    rx_char_o  = 8'h00;
    rx_valid_o = 1'b0;
    brk_o      = 1'b0;
    toggle     = 1'b0;
  end

  // Slow mode withholds ready every other cycle to stretch replies
  assign tx_ready_o = slow_i ? toggle : 1'b1;

  // Collect every character the sensor hands over
  always @(posedge clock_i) begin
    toggle <= ~toggle;
    if (tx_valid_i && tx_ready_o) begin
      heard_q.push_back(tx_char_i);
    end
  end

  // One character per edge; the idle line shows the inverse, not a stale copy
  // Data fetches are issued by index, only after done or time-out
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clock_i);
      rx_char_o  <= s[i];
      rx_valid_o <= 1'b1;
    end
    @(posedge clock_i);
    rx_char_o  <= ~rx_char_o;
    rx_valid_o <= 1'b0;
  endtask

  // Bus break ahead of a command
  task automatic brk();
    @(posedge clock_i);
    brk_o <= 1'b1;
    @(posedge clock_i);
    brk_o <= 1'b0;
  endtask
endmodule

// ==== verif/sdi12_sensor_command_handler_bench.sv ====
// Self-checking bench of the sensor command handler with a master model.
// Assumes the handler answers within a few hundred cycles of each command.
`timescale 1ns/1ps
`include "sdich_map.svh"

module sdi12_sensor_command_handler_bench;
  typedef struct {
    string cmd;
    string rsp;
  } sdich_tb_row_t;

  logic        clock_i;
  logic        rst_n_i;
  logic [7:0]  rx_char_i;
  logic        rx_valid_i;
  logic        brk_i;
  logic [7:0]  tx_char_o;
  logic        tx_valid_o;
  logic        tx_ready_i;
  logic        meas_done_i;
  logic        meas_start_o;
  logic        meas_conc_o;
  logic        data_cont_o;
  logic        conc_seen;
  logic        cont_seen;
  logic        meas_abort_o;
  logic [3:0]  cmd_idx_o;
  logic        ext_cmd_o;
  logic        data_req_o;
  logic [7:0]  data_char_i;
  logic        data_valid_i;
  logic        data_end_i;
  logic        data_ready_o;
  logic        slow;
  logic [3:0]  idx_seen;
  int          bad_count;
  int          check_count;
  int          n_start;
  int          n_abort;
  int          n_ext;
  int          d_idx;
  int          n;
  int          snap;
  string       stream;
  string       s;
  sdich_tb_row_t rows[6];

  // ************************************************************
  // Clock, design and master model
  // ************************************************************
  always #5 clock_i = ~clock_i;

  sdich_handler dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(8'h30),
    .rx_char_i(rx_char_i), .rx_valid_i(rx_valid_i), .brk_i(brk_i),
    .tx_char_o(tx_char_o), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i), .meas_ttt_i(24'h303132),
    .meas_nn_i(16'h3033), .meas_done_i(meas_done_i),
    .meas_start_o(meas_start_o), .meas_conc_o(meas_conc_o),
    .meas_abort_o(meas_abort_o),
    .cmd_idx_o(cmd_idx_o), .ext_cmd_o(ext_cmd_o), .data_req_o(data_req_o),
    .data_cont_o(data_cont_o), .data_char_i(data_char_i),
    .data_valid_i(data_valid_i),
    .data_end_i(data_end_i), .data_ready_o(data_ready_o));

  sdich_host_model host (
    .clock_i(clock_i), .rx_char_o(rx_char_i), .rx_valid_o(rx_valid_i),
    .brk_o(brk_i), .tx_char_i(tx_char_o), .tx_valid_i(tx_valid_o),
    .tx_ready_o(tx_ready_i), .slow_i(slow));

  // ************************************************************
  // Measurement core stand-in and pulse counters
  // ************************************************************
  // A new chunk request restarts the stream, dropping any excess
  always @(posedge clock_i) begin
    n = data_req_o ? 0 : d_idx + ((data_valid_i && data_ready_o) ? 1 : 0);
    d_idx        <= n;
    data_valid_i <= n < stream.len();
    data_end_i   <= n >= stream.len();
    data_char_i  <= (n < stream.len()) ? stream[n] : 8'h00;
    if (data_req_o === 1'b1) begin
      idx_seen  <= cmd_idx_o;
      cont_seen <= data_cont_o;
    end
    if (meas_start_o === 1'b1) begin
      n_start++;
      conc_seen <= meas_conc_o;
    end
    if (meas_abort_o === 1'b1) n_abort++;
    if (ext_cmd_o === 1'b1) n_ext++;
  end

  // ************************************************************
  // Checking helpers
  // ************************************************************
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Empty expectation means the sensor must stay quiet for a while
  task automatic expect_reply(input string what, input string exp);
    int i;
    i = 0;
    if (exp.len() == 0) begin
      repeat (30) @(posedge clock_i);
      check(what, 16'(host.heard_q.size()), 16'h0000);
    end else begin
      while (!(host.heard_q.size() > 0 && host.heard_q[$] === 8'h0a)) begin
        @(posedge clock_i);
        i++;
        if (i > 800) begin
          bad_count++;
          $display("ERROR %s expected reply seen none", what);
          results();
        end
      end
      check(what, 16'(host.heard_q.size()), 16'(exp.len()));
      for (i = 0; i < exp.len() && i < host.heard_q.size(); i++) begin
        check(what, {8'h00, host.heard_q[i]}, {8'h00, exp[i]});
        if (host.heard_q[i] !== exp[i]) break;
      end
    end
    host.heard_q.delete();
  endtask

  task automatic done_pulse();
    @(posedge clock_i);
    meas_done_i <= 1'b1;
    @(posedge clock_i);
    meas_done_i <= 1'b0;
  endtask

  // Reference CRC over address and data characters, three-letter form
  // Master-side check of the appended code
  function automatic string crc_chars(input string t);
    logic [15:0] c;
    string       r;
    c = `SDICH_CRC_INIT;
    r = "@@@";
    for (int i = 0; i < t.len(); i++) begin
      c = c ^ {8'h00, t[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ `SDICH_CRC_POLY) : (c >> 1);
      end
    end
    r[0] = 8'h40 | {4'h0, c[15:12]};
    r[1] = 8'h40 | {2'b00, c[11:6]};
    r[2] = 8'h40 | {2'b00, c[5:0]};
    return r;
  endfunction

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    clock_i = 1'b0;
    rst_n_i = 1'b0;
    meas_done_i = 1'b0;
    slow = 1'b0;
    stream = "";
    rows[0] = '{"0!", "0\r\n"};
    rows[1] = '{"1M!", ""};
    rows[2] = '{"?!", "0\r\n"};
    rows[3] = '{"0XAB!", "0\r\n"};
    rows[4] = '{"0M!", "00123\r\n"};
    rows[5] = '{"0C!", "001203\r\n"};
    repeat (2) @(posedge clock_i);
    check("tx_valid in reset", {15'h0, tx_valid_o}, 16'h0000);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    $display("reset test done");

    // Plain command rows
    foreach (rows[k]) begin
      host.send(rows[k].cmd);
      expect_reply(rows[k].cmd, rows[k].rsp);
    end
    check("extended pulses", 16'(n_ext), 16'h0001);
    check("starts", 16'(n_start), 16'h0002);
    check("conc flag", {15'h0, conc_seen}, 16'h0001);
    $display("row tests done");

    // Any valid command while concurrent is pending aborts it
    snap = n_abort;
    host.send("0!");
    expect_reply("ack", "0\r\n");
    check("concurrent abort", 16'(n_abort - snap), 16'h0001);
    $display("concurrent abort test done");

    // Break during a standard measurement abandons it
    host.send("0M!");
    expect_reply("start", "00123\r\n");
    check("std flag", {15'h0, conc_seen}, 16'h0000);
    snap = n_abort;
    host.brk();
    repeat (3) @(posedge clock_i);
    check("break abort", 16'(n_abort - snap), 16'h0001);
    $display("break abort test done");

    // Standard chunk cut at its limit, stalled transmitter
    slow <= 1'b1;
    host.send("0M!");
    expect_reply("start", "00123\r\n");
    done_pulse();
    expect_reply("service request", "0\r\n");
    stream = "+123456789012345678901234567890123456789";
    host.send("0D0!");
    expect_reply("std", {"0", stream.substr(0, 34), "\r\n"});
    slow <= 1'b0;
    $display("standard chunk test done");

    // Concurrent: no service request, sign added, index passed on
    host.send("0C!");
    expect_reply("conc start", "001203\r\n");
    done_pulse();
    expect_reply("no service request", "");
    stream = "7-2";
    host.send("0D9!");
    expect_reply("signed chunk", "0+7-2\r\n");
    check("data index", {12'h000, idx_seen}, 16'h0009);
    check("send data flag", {15'h0, cont_seen}, 16'h0000);
    s = "+";
    repeat (8) s = {s, "1234567890"};
    stream = s;
    host.send("0D1!");
    expect_reply("conc chunk", {"0", s.substr(0, 74), "\r\n"});
    $display("concurrent chunk test done");

    // CRC variant appends three characters before the line end
    host.send("0MC!");
    expect_reply("crc start", "00123\r\n");
    done_pulse();
    expect_reply("crc service request", "0\r\n");
    stream = "+1";
    host.send("0D0!");
    expect_reply("crc chunk", {"0+1", crc_chars("0+1"), "\r\n"});
    $display("crc test done");

    // Continuous fetch with CRC carries its own index and flag
    stream = "+5";
    host.send("0RC3!");
    expect_reply("cont", {"0+5", crc_chars("0+5"), "\r\n"});
    check("continuous flag", {15'h0, cont_seen}, 16'h0001);
    check("continuous index", {12'h000, idx_seen}, 16'h0003);
    $display("continuous test done");
    results();
  end
endmodule
